/* File: rtl/bus_watchdog_map.vh */
/*
 Constants for the host-bus watchdog: command code, field layout,
 reset value, timing counts, masked key value and the police load value.
 Assumes inclusion by bare name from the watchdog design files.
*/
`ifndef BUS_WATCHDOG_MAP_VH
`define BUS_WATCHDOG_MAP_VH
`define WD_CMD_CONTROL 8'h42
`define WD_BIT_FLAG 0
`define WD_KEY_LSB 1
`define WD_KEY_MSB 4
`define WD_KEY_MASKED 4'hb
`define WD_CONTROL_RESET 8'h16
`define WD_CLOCK_HZ 50000000
`define WD_TIMEOUT_MS 2000
`define WD_TICK_US 1000
`define WD_PRESCALE_CYCLES ((`WD_CLOCK_HZ / 1000000) * `WD_TICK_US)
`define WD_TIMEOUT_TICKS (`WD_TIMEOUT_MS * 1000 / `WD_TICK_US)
`define WD_POLICE_ONES 8'hff
`endif

/* File: rtl/edge_timer.v */
/*
 Prescaled inactivity timer: a tick prescaler and a tick counter,
 both restarted by a one-cycle restart pulse; pulses expired once.
 Assumes restart comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_watchdog_map.vh"
module edge_timer #(
   parameter PRESCALE = 50000,
   parameter TICKS = 2000
) (
   input wire clock,
   input wire rst,
   input wire restart,
   output reg expired
);
   reg [31:0] pre_r; // Cycles within a tick
   reg [31:0] tick_r; // Ticks since last restart
   reg done_r; // Already expired since restart

   // Prescaler and tick count, cleared on each edge
   always @(posedge clock) begin
      if (rst || restart) begin
         pre_r <= 32'h0;
         tick_r <= 32'h0;
         done_r <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (pre_r == PRESCALE - 1) begin
            pre_r <= 32'h0;
            if (!done_r) begin
               if (tick_r == TICKS - 1) begin
                  expired <= 1'b1;
                  done_r <= 1'b1;
                  tick_r <= 32'h0;
               end else begin
                  tick_r <= tick_r + 32'h1;
               end
            end
         end else begin
            pre_r <= pre_r + 32'h1;
         end
      end
   end
endmodule // edge_timer
`default_nettype wire

/* File: rtl/i2c_bus_watchdog.v */
/*
 Host-bus watchdog of an eight-channel power controller. Holds the
 watchdog control register and drives the shutdown strobes that clear
 the channel register groups. Assumes the I2C slave decodes commands
 into cmd, wr_en, wr_data and a same-clock read; scl is a raw pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bus_watchdog_map.vh"
module i2c_bus_watchdog #(
   parameter PRESCALE = `WD_PRESCALE_CYCLES,
   parameter TICKS = `WD_TIMEOUT_TICKS,
   parameter CHANNELS = 8
) (
   input wire clock,
   input wire rst,
   input wire scl_in,
   input wire [7:0] cmd,
   input wire wr_en,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   input wire [CHANNELS-1:0] pg_now,
   input wire [CHANNELS-1:0] pe_now,
   output reg expired_pulse,
   output reg channels_off,
   output reg clear_fields,
   output reg load_police_ones,
   output reg [7:0] police_value,
   output reg [CHANNELS-1:0] power_good_status,
   output reg [CHANNELS-1:0] power_enable_status,
   output reg [CHANNELS-1:0] power_good_change_event,
   output reg [CHANNELS-1:0] power_enable_change_event,
   output reg telemetry_freeze,
   output reg expiry_flag
);
   reg scl_s1_r; // Synchroniser first stage
   reg scl_s2_r; // Synchroniser second stage
   reg scl_d_r; // Delayed copy for edge detect
   wire scl_edge; // Either edge on clock line
   wire timer_exp; // Timer ran out
   reg [3:0] watchdog_mask_key; // Mask key field
   wire masked; // Watchdog masked
   wire hit; // Write to control register
   wire flag_clr; // Host writes zero to flag
   localparam [7:0] CTL_RESET = `WD_CONTROL_RESET; // Control byte after reset

   // Two-flop synchroniser, then edge detect on second stage
   always @(posedge clock) begin
      if (rst) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
      end
   end
   assign scl_edge = scl_s2_r ^ scl_d_r;

   // Inactivity timer
   edge_timer #(
      .PRESCALE(PRESCALE),
      .TICKS(TICKS)
   ) u_timer (
      .clock(clock),
      .rst(rst),
      .restart(scl_edge),
      .expired(timer_exp)
   );

   assign hit = wr_en && (cmd == `WD_CMD_CONTROL);
   assign flag_clr = hit && !wr_data[`WD_BIT_FLAG];
   assign masked = (watchdog_mask_key == `WD_KEY_MASKED);

   // Control register: key and sticky flag, set beats clear
   always @(posedge clock) begin
      if (rst) begin
         watchdog_mask_key <= CTL_RESET[`WD_KEY_MSB:`WD_KEY_LSB];
         expiry_flag <= 1'b0;
      end else begin
         if (hit) begin
            watchdog_mask_key <= wr_data[`WD_KEY_MSB:`WD_KEY_LSB];
         end
         if (timer_exp) begin
            expiry_flag <= 1'b1;
         end else if (flag_clr) begin
            expiry_flag <= 1'b0;
         end
      end
   end

   // Read data: control byte, upper bits zero
   always @(posedge clock) begin
      if (rst) begin
         rd_data <= 8'h0;
      end else if (cmd == `WD_CMD_CONTROL) begin
         rd_data <= {3'h0, watchdog_mask_key, expiry_flag};
      end else begin
         rd_data <= 8'h0;
      end
   end

   // Telemetry freeze from expiry until flag cleared
   always @(posedge clock) begin
      if (rst) begin
         telemetry_freeze <= 1'b0;
      end else if (timer_exp) begin
         telemetry_freeze <= 1'b1;
      end else if (flag_clr) begin
         telemetry_freeze <= 1'b0;
      end
   end

   // Shutdown strobes, one cycle after expiry when unmasked
   always @(posedge clock) begin
      if (rst) begin
         expired_pulse <= 1'b0;
         channels_off <= 1'b0;
         clear_fields <= 1'b0;
         load_police_ones <= 1'b0;
         police_value <= 8'h0;
      end else begin
         expired_pulse <= timer_exp;
         channels_off <= timer_exp && !masked;
         clear_fields <= timer_exp && !masked;
         load_police_ones <= timer_exp && !masked;
         police_value <= `WD_POLICE_ONES;
      end
   end

   // Power status and change events; shutdown forces status low
   always @(posedge clock) begin
      if (rst) begin
         power_good_status <= {CHANNELS{1'b0}};
         power_enable_status <= {CHANNELS{1'b0}};
         power_good_change_event <= {CHANNELS{1'b0}};
         power_enable_change_event <= {CHANNELS{1'b0}};
      end else if (timer_exp && !masked) begin
         power_good_status <= {CHANNELS{1'b0}};
         power_enable_status <= {CHANNELS{1'b0}};
         power_good_change_event <= power_good_change_event | power_good_status;
         power_enable_change_event <= power_enable_change_event | power_enable_status;
      end else begin
         power_good_status <= pg_now;
         power_enable_status <= pe_now;
         power_good_change_event <= power_good_change_event | (pg_now ^ power_good_status);
         power_enable_change_event <= power_enable_change_event | (pe_now ^ power_enable_status);
      end
   end
endmodule // i2c_bus_watchdog
`default_nettype wire

/* File: tb/host_model.sv */
/* Host master model: clock-line activity and decoded byte access.
   Assumes the bench clock; drives on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clock,
   output logic scl_in,
   output logic [7:0] cmd,
   output logic wr_en,
   output logic [7:0] wr_data
);
   // Clock line idles high, as its pull-up holds it
   initial begin
      scl_in = 1'b1;
      {cmd, wr_en, wr_data} = '0;
   end
   // Clock-line edges only
   task burst(input int n);
      repeat (n) @(negedge clock) scl_in <= ~scl_in;
   endtask
   // One byte access with a clock edge, as a real transfer has
   task xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
      @(negedge clock) {scl_in, cmd, wr_en, wr_data} <= {~scl_in, c, w, d};
      @(negedge clock) wr_en <= 1'b0;
   endtask
endmodule // host_model
`default_nettype wire

/* File: tb/i2c_bus_watchdog_monitor.sv */
/* Port checker for the bus watchdog.
   Assumes it is bound into every watchdog instance. */
`timescale 1ns/1ps
`default_nettype none
module wd_monitor #(parameter PRESCALE = 4, parameter TICKS = 5) (
   input wire clock,
   input wire rst,
   input wire scl_in,
   input wire [7:0] cmd,
   input wire wr_en,
   input wire [7:0] wr_data,
   input wire expired_pulse,
   input wire channels_off,
   input wire clear_fields,
   input wire load_police_ones,
   input wire [7:0] police_value,
   input wire telemetry_freeze,
   input wire expiry_flag
);
   reg scl_d_r; // Last pin level
   integer idle_r; // Cycles since a pin change
   wire zero_wr = wr_en && cmd == 8'h42 && !wr_data[0]; // Flag clearing write
   // Counts idle cycles on the raw clock pin
   always @(posedge clock) begin
      scl_d_r <= scl_in;
      idle_r <= (rst || scl_in != scl_d_r) ? 0 : idle_r + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_idle_span: assert property (expired_pulse |-> idle_r >= PRESCALE * TICKS) else $error("early");
   chk_expiry_due: assert property (idle_r == PRESCALE * TICKS + 8 |-> expiry_flag) else $error("late");
   chk_strobe_set: assert property (channels_off |-> expired_pulse && clear_fields && load_police_ones)
      else $error("strobes");
   chk_strobe_one: assert property (channels_off |=> !channels_off) else $error("off pulse");
   chk_police_ones: assert property (load_police_ones |-> police_value == 8'hff) else $error("police");
   chk_flag_set: assert property (expired_pulse |-> expiry_flag) else $error("flag set");
   chk_flag_hold: assert property (expiry_flag && !zero_wr |=> expiry_flag) else $error("flag hold");
   chk_flag_clear: assert property (zero_wr ##1 !expired_pulse |-> !expiry_flag) else $error("flag clr");
   chk_freeze_on: assert property (channels_off |-> telemetry_freeze) else $error("freeze");
   cover property (channels_off);
   cover property (expired_pulse && !channels_off);
   cover property (zero_wr ##1 !expiry_flag);
endmodule // wd_monitor
bind i2c_bus_watchdog wd_monitor #(.PRESCALE(PRESCALE), .TICKS(TICKS)) u_mon (.*);
`default_nettype wire

/* File: tb/i2c_bus_watchdog_tb.sv */
/* Bench for the bus watchdog with short counts.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_watchdog_tb;
   logic clock = 0, rst = 1, look = 0;
   logic [7:0] pg_now = 0, pe_now = 0, rd_data, police_value, pgs, pes, pgc, pec, cmd, wr_data, pv;
   logic scl_in, wr_en, exp_p, off, clr, ld, frz, flag;
   logic [3:0] k;
   logic [31:0] seed = 32'h5ad3;
   int num_errors = 0, total_checks = 0, i;
   logic [7:0] rd_q[$], sd_q[$];
   always #10 clock = ~clock;
   host_model u_host (.clock(clock), .scl_in(scl_in), .cmd(cmd), .wr_en(wr_en), .wr_data(wr_data));
   i2c_bus_watchdog #(.PRESCALE(4), .TICKS(5)) u_dut (.clock(clock), .rst(rst), .scl_in(scl_in), .cmd(cmd),
      .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .pg_now(pg_now), .pe_now(pe_now),
      .expired_pulse(exp_p), .channels_off(off), .clear_fields(clr), .load_police_ones(ld),
      .police_value(police_value), .power_good_status(pgs), .power_enable_status(pes),
      .power_good_change_event(pgc), .power_enable_change_event(pec), .telemetry_freeze(frz), .expiry_flag(flag));
   function logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task cmp(input string s, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task rd(input logic [7:0] e);
      u_host.xfer(0, 8'h42, 8'h00);
      rd_q.push_back(e);
      look <= 1;
      @(negedge clock) look <= 0;
   endtask
   task wait_exp(input logic [7:0] e);
      sd_q.push_back(e);
      for (i = 0; i < 60 && flag !== 1'b1; i++) @(negedge clock);
      if (i == 60) num_errors++;
   endtask
   // Compares each result with the oldest note
   always @(posedge clock) begin
      if (look) cmp("rd_data", rd_q.pop_front(), rd_data);
      if (exp_p === 1'b1) cmp("strobes", sd_q.pop_front(), {5'b0, off, clr, ld});
   end
   task wrap_up();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge clock);
      @(negedge clock) rst <= 0;
      rd(8'h16);
      u_host.burst(60);
      rd(8'h16);
      wait_exp(8'h00);
      rd(8'h17);
      u_host.xfer(1, 8'h42, 8'h17);
      rd(8'h17);
      u_host.xfer(1, 8'h42, 8'h16);
      rd(8'h16);
      $display("test masked done");
      k = rnd();
      if (k == 4'hb) k = 4'h0;
      pv = rnd() | 8'h01;
      pg_now <= pv;
      pe_now <= rnd();
      u_host.xfer(1, 8'h42, {3'b0, k, 1'b0});
      wait_exp(8'h07);
      cmp("pg_status", 8'h00, pgs);
      {pg_now, pe_now} <= 16'h0000;
      cmp("pg_event", pv, pgc);
      cmp("freeze", 8'h01, {7'b0, frz});
      u_host.xfer(1, 8'h41, 8'h00);
      rd({3'b0, k, 1'b1});
      u_host.xfer(1, 8'h42, {3'b0, k, 1'b0});
      rd({3'b0, k, 1'b0});
      cmp("freeze", 8'h00, {7'b0, frz});
      $display("test shutdown done");
      wrap_up();
   end
endmodule // i2c_bus_watchdog_tb
`default_nettype wire
